// ---- pkg/lmb_pkg.sv ----
// ==========================================================================
// shared constants of the local memory bank controller
package lmb_pkg;

  localparam int BANKS = 6;
  localparam int FIXED_BANKS = 4;
  localparam int PROG_BANKS = 2;
  localparam int ADDR_W = 32;
  localparam int SPACE_W = 23;
  localparam int REGION_W = ADDR_W - SPACE_W;
  localparam int PIN_LO = 2;
  localparam int PIN_W = SPACE_W - PIN_LO;
  localparam int WAIT_W = 4;
  localparam int DATA_W = 32;
  localparam int SDR_W = 15;

  // port width codes, two bits per bank
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;

  // strap positions on the address pins, as pin index minus two
  localparam int BOOT_HI = 20;
  localparam int BOOT_LO = 19;
  localparam int HOST_POS = 18;
  localparam int MODE_HI = 17;
  localparam int MODE_LO = 15;

  // address pins shared with the dram address: 16..2 without 12
  localparam logic [SDR_W-1:0] SDR_MASK = 15'h7_bff;

  localparam logic [5:0] CS_IDLE = 6'h3f;
  localparam logic [3:0] WE_IDLE = 4'hf;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } lmb_state_t;

endpackage

// ---- src/lmb_lane_map.sv ----
`timescale 1ns/1ps
// ==========================================================================
// write strobe lane steering by port width
module lmb_lane_map (
  input wire logic [1:0] width_in,
  input wire logic [3:0] be_in,
  input wire logic [1:0] addr_lo_in,
  input wire logic cs_active_in,
  input wire logic wr_strobe_in,
  output logic [3:0] we_n_out
);
  import lmb_pkg::*;

  // ==========================================================================
  // narrow ports reuse idle lanes as low address bits while selected
  always_comb
  begin
    we_n_out = WE_IDLE;
    if (cs_active_in)
    begin
      case (width_in)
        W32:
        begin
          we_n_out = wr_strobe_in ? ~be_in : WE_IDLE;
        end
        W16:
        begin
          we_n_out[3] = ~(wr_strobe_in & be_in[1]);
          we_n_out[2] = addr_lo_in[1];
          we_n_out[1] = 1'b0;
          we_n_out[0] = ~(wr_strobe_in & be_in[0]);
        end
        default:
        begin
          we_n_out[3] = 1'b1;
          we_n_out[2] = addr_lo_in[1];
          we_n_out[1] = addr_lo_in[0];
          we_n_out[0] = ~(wr_strobe_in & be_in[0]);
        end
      endcase
    end
  end

endmodule

// ---- src/lmb_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// - six active-low bank selects, the four fixed ones 8MB each
// - each bank is 8, 16 or 32 wide
// - two banks have programmable base and extent
// - wait states inserted from per-bank count
// - burst advances address linear or sub-block
// - 32-bit: four independent byte write strobes
// - 16-bit: high-byte strobe, A1, low, low-byte strobe
// - 8-bit: high, A1, A0, byte strobe
// - selected bank select driven low
// - output enable only for selected reading bank
// - one shared 32-bit two-way data bus
// - plain async devices attach without glue
// - upper address pins double as straps
// - pins 16..2 except 12 carry dram address
// - straps caught at reset release, then address
// - dram bit 12 on own pin
module lmb_ctrl #(
  parameter int BURST_W = 2
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [lmb_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [BURST_W-1:0] req_len_in,
  input wire logic req_subblock_in,
  input wire logic [3:0] req_be_in,
  input wire logic [lmb_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic [2*lmb_pkg::BANKS-1:0] width_cfg_in,
  input wire logic [lmb_pkg::WAIT_W*lmb_pkg::BANKS-1:0] wait_cfg_in,
  input wire logic [lmb_pkg::REGION_W*lmb_pkg::PROG_BANKS-1:0] prog_base_in,
  input wire logic [lmb_pkg::REGION_W*lmb_pkg::PROG_BANKS-1:0] prog_mask_in,
  input wire logic sdram_active_in,
  input wire logic [lmb_pkg::SDR_W-1:0] sdram_addr_in,
  input wire logic sdram_a12_in,
  input wire logic [lmb_pkg::DATA_W-1:0] mem_data_in,
  input wire logic [lmb_pkg::PIN_W-1:0] mem_addr_in,
  output logic req_ready_out,
  output logic beat_done_out,
  output logic acc_err_out,
  output logic [lmb_pkg::DATA_W-1:0] rd_data_out,
  output logic [5:0] mem_cs_n_out,
  output logic mem_oe_n_out,
  output logic [3:0] mem_we_n_out,
  output logic [lmb_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_out,
  output logic [lmb_pkg::PIN_W-1:0] mem_addr_out,
  output logic mem_addr_oe_out,
  output logic sdram_addr12_out,
  output logic [1:0] boot_mode_out,
  output logic pci_host_mode_out,
  output logic [2:0] mode_bits_out
);
  import lmb_pkg::*;

  typedef struct packed {
    lmb_state_t st;
    logic [5:0] cs_n;
    logic oe_n;
    logic [3:0] we_n;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic [PIN_W-1:0] pins;
    logic addr_oe;
    logic a12;
    logic [DATA_W-1:0] rd_data;
    logic beat_done;
    logic acc_err;
    logic ready;
    logic [1:0] width;
    logic write;
    logic sub;
    logic [SPACE_W-1:0] start;
    logic [SPACE_W-1:0] cur;
    logic [BURST_W-1:0] idx;
    logic [BURST_W-1:0] left;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] wait_ld;
    logic [3:0] be;
    logic strap_done;
    logic [1:0] boot;
    logic host;
    logic [2:0] mode;
  } lmb_ctrl_t;

  lmb_ctrl_t s;
  lmb_ctrl_t n;
  logic [3:0] lane_we_n;
  logic lane_cs;
  logic lane_wr;

  // ==========================================================================
  // lane steering sees the next state so strobes leave a flop aligned
  assign lane_cs = (n.st != ST_IDLE);
  assign lane_wr = (n.st == ST_STROBE) && n.write;

  lmb_lane_map u_lane (
    .width_in(n.width),
    .be_in(n.be),
    .addr_lo_in(n.cur[1:0]),
    .cs_active_in(lane_cs),
    .wr_strobe_in(lane_wr),
    .we_n_out(lane_we_n)
  );

  // ==========================================================================
  // beat address: linear steps by port width, sub-block xors index bits
  function automatic logic [SPACE_W-1:0] beat_addr(
    input logic [SPACE_W-1:0] base,
    input logic [BURST_W-1:0] idx,
    input logic [1:0] w,
    input logic sub
  );
    logic [SPACE_W-1:0] step;
    logic [SPACE_W-1:0] fld;
    step = SPACE_W'(idx) << w;
    fld = SPACE_W'({BURST_W{1'b1}}) << w;
    if (sub)
      beat_addr = (base & ~fld) | ((base & fld) ^ step);
    else
      beat_addr = base + step;
  endfunction

  // ==========================================================================
  // next-state logic for the whole controller
  always_comb
  begin
    logic [REGION_W-1:0] region;
    logic hit;
    logic [2:0] bank;
    region = req_addr_in[ADDR_W-1:SPACE_W];
    hit = 1'b0;
    bank = 3'h0;
    n = s;
    n.beat_done = 1'b0;
    n.acc_err = 1'b0;
    // fixed banks sit at region index, programmable ones override
    for (int i = 0; i < BANKS; i++)
    begin
      if (i < FIXED_BANKS)
      begin
        if (region == REGION_W'(i))
        begin
          hit = 1'b1;
          bank = 3'(i);
        end
      end
      else if ((region & prog_mask_in[(i-FIXED_BANKS)*REGION_W +: REGION_W])
        == (prog_base_in[(i-FIXED_BANKS)*REGION_W +: REGION_W]
        & prog_mask_in[(i-FIXED_BANKS)*REGION_W +: REGION_W]))
      begin
        hit = 1'b1;
        bank = 3'(i);
      end
    end
    case (s.st)
      ST_IDLE:
      begin
        // dram owns the shared pins while active, so local waits
        if (req_valid_in && s.ready && !sdram_active_in)
        begin
          if (hit)
          begin
            n.st = ST_SETUP;
            n.cs_n = ~(6'h01 << bank);
            n.width = width_cfg_in[2*bank +: 2];
            n.wait_ld = wait_cfg_in[WAIT_W*bank +: WAIT_W];
            n.write = req_write_in;
            n.sub = req_subblock_in;
            n.start = req_addr_in[SPACE_W-1:0];
            n.cur = req_addr_in[SPACE_W-1:0];
            n.idx = '0;
            n.left = req_len_in;
            n.be = req_be_in;
          end
          else
          begin
            n.acc_err = 1'b1;
          end
        end
      end
      ST_SETUP:
      begin
        // data and lanes for this beat are taken as the strobe opens
        n.st = ST_STROBE;
        n.wait_cnt = s.wait_ld;
        n.be = req_be_in;
        n.wdata = req_wdata_in;
        n.data_oe = s.write;
      end
      ST_STROBE:
      begin
        if (s.wait_cnt == '0)
        begin
          n.st = ST_HOLD;
          n.beat_done = 1'b1;
          if (!s.write)
            n.rd_data = mem_data_in;
        end
        else
        begin
          n.wait_cnt = s.wait_cnt - 1'b1;
        end
      end
      ST_HOLD:
      begin
        // hold phase keeps address and data stable past the strobe
        n.data_oe = 1'b0;
        if (s.left != '0)
        begin
          n.st = ST_SETUP;
          n.left = s.left - 1'b1;
          n.idx = s.idx + 1'b1;
          n.cur = beat_addr(s.start, s.idx + 1'b1, s.width, s.sub);
        end
        else
        begin
          n.st = ST_IDLE;
          n.cs_n = CS_IDLE;
        end
      end
      default:
      begin
        n.st = ST_IDLE;
        n.cs_n = CS_IDLE;
        n.data_oe = 1'b0;
      end
    endcase
    // oe only for a reading strobe, strobes only on writes
    n.oe_n = !((n.st == ST_STROBE) && !n.write);
    n.we_n = lane_we_n;
    n.ready = (n.st == ST_IDLE) && s.strap_done;
    // straps are taken at the first edge after reset release
    if (!s.strap_done)
    begin
      n.boot = mem_addr_in[BOOT_HI:BOOT_LO];
      n.host = mem_addr_in[HOST_POS];
      n.mode = mem_addr_in[MODE_HI:MODE_LO];
      n.strap_done = 1'b1;
      n.ready = 1'b0;
    end
    n.addr_oe = 1'b1;
    n.pins = n.cur[SPACE_W-1:PIN_LO];
    if (sdram_active_in)
      n.pins[SDR_W-1:0] = (n.pins[SDR_W-1:0] & ~SDR_MASK)
        | (sdram_addr_in & SDR_MASK);
    n.a12 = sdram_a12_in;
  end

  // ==========================================================================
  // state register; everything deasserted while reset is held
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cs_n <= CS_IDLE;
      s.oe_n <= 1'b1;
      s.we_n <= WE_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================================
  // ports come straight from the state register
  assign req_ready_out = s.ready;
  assign beat_done_out = s.beat_done;
  assign acc_err_out = s.acc_err;
  assign rd_data_out = s.rd_data;
  assign mem_cs_n_out = s.cs_n;
  assign mem_oe_n_out = s.oe_n;
  assign mem_we_n_out = s.we_n;
  assign mem_data_out = s.wdata;
  assign mem_data_oe_out = s.data_oe;
  assign mem_addr_out = s.pins;
  assign mem_addr_oe_out = s.addr_oe;
  assign sdram_addr12_out = s.a12;
  assign boot_mode_out = s.boot;
  assign pci_host_mode_out = s.host;
  assign mode_bits_out = s.mode;

  // ==========================================================================
  // checks
  cs_onehot_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $onehot0(~mem_cs_n_out)) else $error("two bank selects low");
  oe_excl_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !mem_oe_n_out |-> !mem_data_oe_out && mem_cs_n_out != CS_IDLE
    && (s.width != W32 || mem_we_n_out == WE_IDLE))
    else $error("oe with write or no select");
  w8_lanes_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (s.st != ST_IDLE && s.width == W8) |->
    mem_we_n_out[3] && mem_we_n_out[2:1] == s.cur[1:0])
    else $error("8-bit lane map wrong");
  w16_lanes_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (s.st != ST_IDLE && s.width == W16) |->
    !mem_we_n_out[1] && mem_we_n_out[2] == s.cur[1])
    else $error("16-bit lane map wrong");
  wait_len_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (s.st == ST_STROBE && s.wait_cnt == 4'h1) |=>
    s.st == ST_STROBE ##1 s.st == ST_HOLD && beat_done_out)
    else $error("wait state count wrong");
  burst_lin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (s.st == ST_HOLD && s.left != '0 && !s.sub && s.width == W32) |=>
    s.cur == $past(s.cur) + 23'h00_0004)
    else $error("linear burst step wrong");
  sdr_pins_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(sdram_active_in) && s.strap_done |->
    (mem_addr_out[SDR_W-1:0] & SDR_MASK) == ($past(sdram_addr_in) & SDR_MASK))
    else $error("dram address not on pins");
  a12_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ##1 sdram_addr12_out == $past(sdram_a12_in))
    else $error("dram bit 12 wrong");
  strap_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $past(s.strap_done) |-> $stable(boot_mode_out) && $stable(mode_bits_out)
    && $stable(pci_host_mode_out)) else $error("strap changed");
  reset_idle_a: assert property (@(posedge ref_clk_in)
    sys_rst_in |=> mem_cs_n_out == CS_IDLE && mem_oe_n_out
    && mem_we_n_out == WE_IDLE) else $error("controls not idle");

endmodule

// ---- bench/lmb_mem_model.sv ----
`timescale 1ns/1ps
// ====================
// far side: one 32-bit bank holds a small memory, pulls hold the straps
module lmb_mem_model #(
  parameter logic [20:0] STRAP = 21'h15_0000,
  parameter int LANE_CS = 2
) (
  input wire logic ref_clk_in,
  input wire logic [5:0] cs_n_in,
  input wire logic oe_n_in,
  input wire logic [3:0] we_n_in,
  input wire logic [20:0] addr_in,
  input wire logic addr_oe_in,
  input wire logic [31:0] data_in,
  input wire logic data_oe_in,
  output logic [31:0] data_out,
  output logic [20:0] addr_out
);
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0;
  logic drive;
  // released pins fall back to the strap resistors
  assign addr_out = addr_oe_in ? addr_in : STRAP;
  assign drive = !oe_n_in && (cs_n_in != 6'h3f);
  // an idle bus shows the inverse of its last value, not a stale copy
  assign data_out = data_oe_in ? data_in :
                    drive ? mem[addr_in[3:0]] : ~last;
  // each lane is written on its own strobe
  always @(posedge ref_clk_in)
  begin
    last <= data_out;
    for (int i = 0; i < 4; i++)
      if (!cs_n_in[LANE_CS] && !we_n_in[i] && data_oe_in)
        mem[addr_in[3:0]][8*i +: 8] <= data_in[8*i +: 8];
  end
endmodule

// ---- bench/local_memory_byte_lane_control_tb.sv ----
`timescale 1ns/1ps
// ====================
// self-checking bench of the bank controller
module local_memory_byte_lane_control_tb;
  import lmb_pkg::*;
  typedef struct {
    logic [31:0] addr; logic wr; logic [3:0] be; logic [31:0] wd;
    logic [31:0] cs; logic [31:0] we; logic [31:0] oe; logic [31:0] lat;
  } lmb_row_t;
  logic ref_clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic req_valid_in = 1'h0, req_write_in = 1'h0, req_subblock_in = 1'h0;
  logic sdram_active_in = 1'h0, sdram_a12_in = 1'h0;
  logic [31:0] req_addr_in = 32'h0, req_wdata_in = 32'h0;
  logic [1:0] req_len_in = 2'h0;
  logic [3:0] req_be_in = 4'h0;
  logic [14:0] sdram_addr_in = 15'h0;
  // bank 0 is 8 bit, bank 1 16 bit, the rest 32 bit
  logic [11:0] width_cfg_in = 12'haa4;
  logic [23:0] wait_cfg_in = 24'h03_2001;
  logic [17:0] prog_base_in = 18'h0_4020;
  logic [17:0] prog_mask_in = 18'h3_e1e0;
  logic [31:0] mem_data_in, rd_data_out, mem_data_out;
  logic [20:0] mem_addr_in, mem_addr_out;
  logic req_ready_out, beat_done_out, acc_err_out, mem_oe_n_out;
  logic mem_data_oe_out, mem_addr_oe_out, sdram_addr12_out;
  logic pci_host_mode_out;
  logic [5:0] mem_cs_n_out;
  logic [3:0] mem_we_n_out;
  logic [1:0] boot_mode_out;
  logic [2:0] mode_bits_out;
  logic [31:0] s_cs, s_we, s_oe, s_lat, s_err;
  logic [20:0] bq [4];
  int nb, error_cnt = 0, n_compared = 0, cyc = 0;
  lmb_row_t rows [10] = '{
    '{32'h0000_0002, 1'h1, 4'h1, 32'hab, 6'h3e, 4'hc, 1'h1, 32'h4},
    '{32'h0000_0001, 1'h0, 4'h0, 32'h0, 6'h3e, 4'hb, 1'h0, 32'h4},
    '{32'h0080_0002, 1'h1, 4'h3, 32'hcdef, 6'h3d, 4'h4, 1'h1, 32'h3},
    '{32'h0080_0000, 1'h0, 4'h0, 32'h0, 6'h3d, 4'h9, 1'h0, 32'h3},
    '{32'h0100_0008, 1'h1, 4'ha, 32'h1234_5678, 6'h3b, 4'h5, 1'h1, 32'h3},
    '{32'h0100_0008, 1'h1, 4'h5, 32'h9abc_def0, 6'h3b, 4'ha, 1'h1, 32'h3},
    '{32'h0100_0008, 1'h0, 4'h0, 32'h0, 6'h3b, 4'hf, 1'h0, 32'h3},
    '{32'h0180_0000, 1'h0, 4'h0, 32'h0, 6'h37, 4'hf, 1'h0, 32'h5},
    '{32'h1800_0000, 1'h0, 4'h0, 32'h0, 6'h2f, 4'hf, 1'h0, 32'h6},
    '{32'h1280_0000, 1'h1, 4'hf, 32'h0, 6'h1f, 4'h0, 1'h1, 32'h3}};

  lmb_ctrl dut_u (.*);
  lmb_mem_model mdl_u (.ref_clk_in(ref_clk_in), .cs_n_in(mem_cs_n_out),
    .oe_n_in(mem_oe_n_out), .we_n_in(mem_we_n_out),
    .addr_in(mem_addr_out), .addr_oe_in(mem_addr_oe_out),
    .data_in(mem_data_out), .data_oe_in(mem_data_oe_out),
    .data_out(mem_data_in), .addr_out(mem_addr_in));

  always #4 ref_clk_in = ~ref_clk_in;

  // ====================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one request; samples at falling edges so registered outputs settled
  task automatic issue(input logic [31:0] a, input logic w,
    input logic [3:0] b, input logic [31:0] d, input logic [1:0] n,
    input logic s);
    int k;
    k = 0;
    nb = 0;
    {s_cs, s_we, s_oe, s_err, s_lat} = {32'h3f, 32'hf, 32'h1, 64'h0};
    while (req_ready_out !== 1'h1 && k < 40)
    begin
      @(negedge ref_clk_in);
      k++;
    end
    @(posedge ref_clk_in);
    {req_valid_in, req_addr_in, req_write_in} <= {1'h1, a, w};
    {req_be_in, req_wdata_in, req_len_in, req_subblock_in} <= {b, d, n, s};
    @(posedge ref_clk_in);
    req_valid_in <= 1'h0;
    k = 0;
    // first look falls in the cycle right after the take edge, so the
    // one-cycle error pulse is not missed
    while (nb <= n && s_err == 0 && k < 40)
    begin
      @(negedge ref_clk_in);
      k++;
      if (k == 1)
        s_cs = mem_cs_n_out;
      if (mem_cs_n_out !== 6'h3f)
        {s_we, s_oe} = {s_we & mem_we_n_out, s_oe & mem_oe_n_out};
      if (acc_err_out === 1'h1)
        {s_err, s_lat} = {32'h1, 32'(k)};
      if (beat_done_out === 1'h1)
      begin
        if (nb == 0)
          s_lat = 32'(k);
        bq[nb] = mem_addr_out;
        nb++;
      end
    end
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // ====================
  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk({mem_cs_n_out, mem_oe_n_out, mem_we_n_out}, 32'h7ff);
    chk({mem_addr_oe_out, req_ready_out}, 32'h0);
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'h0;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk({boot_mode_out, pci_host_mode_out, mode_bits_out}, 32'h2a);
    chk(mem_addr_oe_out, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      issue(rows[i].addr, rows[i].wr, rows[i].be, rows[i].wd, 2'h0, 1'h0);
      chk(s_cs, rows[i].cs);
      chk(s_we, rows[i].we);
      chk(s_oe, rows[i].oe);
      chk(s_lat, rows[i].lat);
      if (i == 6)
        chk(rd_data_out, 32'h12bc_56f0);
    end
    $display("test table done");
    for (int s = 0; s < 2; s++)
    begin
      issue(32'h0100_0004, 1'h0, 4'h0, 32'h0, 2'h3, 1'(s));
      for (int j = 0; j < 4; j++)
        chk(32'(bq[j]), s ? 32'(1 ^ j) : 32'(1 + j));
    end
    $display("test burst done");
    issue(32'h2000_0000, 1'h0, 4'h0, 32'h0, 2'h0, 1'h0);
    chk(s_err, 32'h1);
    chk(s_lat, 32'h1);
    chk(s_cs, 32'h3f);
    $display("test unmapped done");
    @(posedge ref_clk_in);
    {sdram_active_in, sdram_addr_in, sdram_a12_in} <= {1'h1, 15'h5a5a, 1'h1};
    {req_valid_in, req_addr_in} <= {1'h1, 32'h0100_0000};
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(mem_addr_out[14:0] & SDR_MASK, 15'h5a5a & SDR_MASK);
    chk(sdram_addr12_out, 32'h1);
    chk(mem_cs_n_out, 32'h3f);
    @(posedge ref_clk_in);
    {req_valid_in, sdram_active_in} <= 2'h0;
    repeat (8) @(posedge ref_clk_in);
    $display("test shared pins done");
    test_done();
  end
endmodule
